// ### hdl/cmd_interp.sv
/*
  Remote-register command interpreter of a motor drive with its AHB-Lite
  register slave, working and non-volatile operation data, monitor logic
  and remote input word decode. Assumes one clock, synchronous inputs and
  a single AHB-Lite master.
*/
// How it works
// - Command word holds code plus execute flag 4000h; one write selects and fires.
// - Request holds address number, command word and data value in fixed slots.
// - Finished parameter write sets the write-done acknowledge.
// - Executed writes go to working storage; batch command copies to non-volatile.
// - Remote input word bits map to select, start, home, stop, jog and run.
// - Input word 9h starts positioning with the entry chosen by select bits.
// - Monitor keeps sampling its item while the execute flag stays on and the request address still matches the node.
// - Response carries sampled value plus echoed address, command and status.
// - One monitor at a time; host changes address between monitors.
// - Code 2040h monitors the present alarm of the addressed axis.
// - Code 1201h writes travel amount of operation entry 1.
`include "cmd_interp_regs.svh"

module cmd_interp (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Drive side
  input wire logic [15:0] node_addr,
  input wire logic [7:0] alarm_code,
  output cmd_interp_pkg::motion_t motion
);
  import cmd_interp_pkg::*;

  logic [15:0] req_addr_q;
  logic [15:0] cmd_q;
  logic [31:0] req_data_q;
  logic [15:0] io_q;
  logic [15:0] io_prev_q;
  logic [7:0] a_q;
  logic hi_ok_q;
  logic wr_pend_q;
  logic [1:0] rd_ph_q;
  logic [31:0] hrdata_q;
  logic flag_prev_q;
  logic ack_q;
  logic err_q;
  logic nv_go_q;
  logic [15:0] rsp_addr_q;
  logic [13:0] rsp_code_q;
  logic [31:0] rsp_data_q;
  logic [7:0][31:0] work_q;
  logic [7:0][31:0] nv_q;
  state_t state_q;
  motion_t motion_q;
  logic acc;
  logic bus_wr;
  logic exec_on;
  logic flag_rise;
  logic [13:0] code;
  logic [2:0] wr_idx;

  function automatic logic in_bank(input logic [7:0] a,
                                   input logic [7:0] base);
    in_bank = (a[7:5] == base[7:5]);
  endfunction

  function automatic logic is_wr_code(input logic [13:0] c);
    is_wr_code = ((c & `CODE_WR_MASK) == `CODE_WR_TRAVEL);
  endfunction

  assign acc = hsel && htrans[1] && hready;
  assign bus_wr = wr_pend_q && hi_ok_q;
  // A read takes one wait state so that a write just before it is visible.
  assign hreadyout = (rd_ph_q != 2'd1);
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign motion = motion_q;

  assign code = cmd_q[13:0];
  assign exec_on = cmd_q[`EXEC_BIT];
  assign flag_rise = exec_on && !flag_prev_q && (req_addr_q == node_addr);
  assign wr_idx = code[2:0];

  always_ff @(posedge mclk) begin
    if (srst) begin
      a_q <= 8'h00;
      hi_ok_q <= 1'b0;
      wr_pend_q <= 1'b0;
      rd_ph_q <= 2'd0;
    end else if (acc) begin
      a_q <= haddr[7:0];
      hi_ok_q <= (haddr[31:8] == 24'h00_0000) && (hsize == `HSIZE_WORD);
      wr_pend_q <= hwrite;
      rd_ph_q <= hwrite ? 2'd0 : 2'd1;
    end else begin
      wr_pend_q <= 1'b0;
      rd_ph_q <= (rd_ph_q == 2'd1) ? 2'd2 : 2'd0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      hrdata_q <= `RST_WORD;
    end else if (rd_ph_q == 2'd1) begin
      if (!hi_ok_q) begin
        hrdata_q <= `RST_WORD;
      end else if (in_bank(a_q, `OFS_WORK_BASE)) begin
        hrdata_q <= work_q[a_q[4:2]];
      end else if (in_bank(a_q, `OFS_NV_BASE)) begin
        hrdata_q <= nv_q[a_q[4:2]];
      end else begin
        case (a_q)
          `OFS_REQ_ADDR: hrdata_q <= {16'h0000, req_addr_q};
          `OFS_CMD_WORD: hrdata_q <= {16'h0000, cmd_q};
          `OFS_REQ_DATA: hrdata_q <= req_data_q;
          `OFS_IO_IN: hrdata_q <= {16'h0000, io_q};
          `OFS_RSP_ADDR: hrdata_q <= {16'h0000, rsp_addr_q};
          `OFS_RSP_CMD: hrdata_q <= {16'h0000, err_q,
                                     ack_q || (state_q == st_mon),
                                     rsp_code_q};
          `OFS_RSP_DATA: hrdata_q <= rsp_data_q;
          `OFS_STATUS: hrdata_q <= {29'h0, err_q,
                                    state_q == st_mon, ack_q};
          default: hrdata_q <= `RST_WORD;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      req_addr_q <= `RST_HALF;
      cmd_q <= `RST_HALF;
      req_data_q <= `RST_WORD;
      io_q <= `RST_HALF;
    end else if (bus_wr) begin
      case (a_q)
        `OFS_REQ_ADDR: req_addr_q <= hwdata[15:0];
        `OFS_CMD_WORD: cmd_q <= hwdata[15:0];
        `OFS_REQ_DATA: req_data_q <= hwdata;
        `OFS_IO_IN: io_q <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      nv_go_q <= 1'b0;
    end else begin
      nv_go_q <= bus_wr && (a_q == `OFS_NV_CMD) && hwdata[0];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      flag_prev_q <= 1'b0;
    end else begin
      flag_prev_q <= exec_on;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= st_idle;
    end else begin
      case (state_q)
        st_idle: begin
          if (flag_rise && is_wr_code(code)) begin
            state_q <= st_write;
          end else if (flag_rise && code == `CODE_MON_ALARM) begin
            state_q <= st_mon;
          end else if (flag_rise) begin
            state_q <= st_hold;
          end
        end
        st_write: state_q <= st_hold;
        st_mon: if (!exec_on || req_addr_q != node_addr) begin
          state_q <= st_idle;
        end
        st_hold: if (!exec_on) begin
          state_q <= st_idle;
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else if (state_q == st_write) begin
      ack_q <= 1'b1;
    end else if (!exec_on) begin
      ack_q <= 1'b0;
    end
  end

  // Unknown codes are flagged until the host drops the execute flag.
  always_ff @(posedge mclk) begin
    if (srst) begin
      err_q <= 1'b0;
    end else if (state_q == st_idle && flag_rise && !is_wr_code(code) &&
                 code != `CODE_MON_ALARM) begin
      err_q <= 1'b1;
    end else if (!exec_on) begin
      err_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rsp_addr_q <= `RST_HALF;
      rsp_code_q <= 14'h0000;
    end else if (flag_rise) begin
      rsp_addr_q <= req_addr_q;
      rsp_code_q <= code;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rsp_data_q <= `RST_WORD;
    end else if (state_q == st_mon && exec_on) begin
      rsp_data_q <= {24'h00_0000, alarm_code};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_entry
      always_ff @(posedge mclk) begin
        if (srst) begin
          work_q[gi] <= `RST_WORD;
        end else if (state_q == st_write && wr_idx == 3'(gi)) begin
          work_q[gi] <= req_data_q;
        end
      end
      always_ff @(posedge mclk) begin
        if (srst) begin
          nv_q[gi] <= `RST_WORD;
        end else if (nv_go_q) begin
          nv_q[gi] <= work_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (srst) begin
      io_prev_q <= `RST_HALF;
    end else begin
      io_prev_q <= io_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      motion_q <= '0;
    end else begin
      motion_q.start <= io_q[`IO_START] && !io_prev_q[`IO_START];
      if (io_q[`IO_START] && !io_prev_q[`IO_START]) begin
        motion_q.data_select <= io_q[`IO_SEL_LSB +: 3];
        motion_q.travel <= work_q[io_q[`IO_SEL_LSB +: 3]];
      end
      motion_q.home <= io_q[`IO_HOME];
      motion_q.stop <= io_q[`IO_STOP];
      motion_q.free <= io_q[`IO_FREE];
      motion_q.alarm_clear <= io_q[`IO_ALM_CLR];
      motion_q.direct_select <= io_q[`IO_DSEL_LSB +: 3];
      motion_q.sequential_start <= io_q[`IO_SEQUENTIAL_START];
      motion_q.jog_plus <= io_q[`IO_JOG_P];
      motion_q.jog_minus <= io_q[`IO_JOG_M];
      motion_q.forward_run <= io_q[`IO_FWD];
      motion_q.reverse_run <= io_q[`IO_RVS];
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  // Checks below watch the interpreter's own decisions.
  exec_decode_a: assert property (
    flag_rise && state_q == st_idle && is_wr_code(code) |=>
      state_q == st_write)
    else $error("write command not taken on flag rise");
  write_ack_a: assert property (
    state_q == st_write |=> ack_q ##0 work_q[$past(wr_idx)] ==
      $past(req_data_q))
    else $error("write finished without acknowledge");
  one_shot_a: assert property (
    state_q == st_write |=> state_q == st_hold)
    else $error("write repeated while flag held");
  nv_guard_a: assert property (
    !nv_go_q |=> $stable(nv_q))
    else $error("non-volatile data changed without batch command");
  io_map_a: assert property (
    ##1 motion_q.forward_run == $past(io_q[`IO_FWD]) &&
      motion_q.stop == $past(io_q[`IO_STOP]) &&
      motion_q.direct_select == $past(io_q[`IO_DSEL_LSB +: 3]))
    else $error("input word decode mismatch");
  pos_start_a: assert property (
    io_q[`IO_START] && !io_prev_q[`IO_START] |=> motion_q.start &&
      motion_q.data_select == $past(io_q[2:0]) &&
      motion_q.travel == $past(work_q[io_q[2:0]]))
    else $error("positioning start wrong");
  mon_sample_a: assert property (
    state_q == st_mon && exec_on |=>
      rsp_data_q == {24'h00_0000, $past(alarm_code)})
    else $error("monitor value not sampled");
  mon_freeze_a: assert property (
    state_q != st_mon |=> $stable(rsp_data_q))
    else $error("response data moved outside monitor");
  rsp_echo_a: assert property (
    flag_rise |=> rsp_addr_q == $past(req_addr_q) &&
      rsp_code_q == $past(code))
    else $error("response echo wrong");
  alarm_mon_a: assert property (
    flag_rise && state_q == st_idle && code == `CODE_MON_ALARM |=>
      state_q == st_mon ##1 state_q == st_mon || !exec_on ||
      req_addr_q != node_addr)
    else $error("alarm monitor not started");
  entry1_wr_a: assert property (
    state_q == st_write && wr_idx == 3'd1 |=>
      work_q[1] == $past(req_data_q) ##0 work_q[0] == $past(work_q[0]))
    else $error("entry write mismatch");

  write_cycle_c: cover property (
    state_q == st_write ##1 ack_q [*2] ##[1:100] !ack_q);
  monitor_cycle_c: cover property (
    state_q == st_mon [*3] ##1 state_q == st_idle);
  nv_copy_c: cover property (nv_go_q);
  start_c: cover property (motion_q.start && motion_q.data_select == 3'd1);

endmodule // cmd_interp

// ### hdl/cmd_interp_regs.svh
/*
  Register offsets, field positions, reset values and command codes of the
  remote-register command interpreter. Assumes byte addresses on a 32-bit
  AHB-Lite bus with one aligned word per register.
*/
`ifndef CMD_INTERP_REGS_SVH
`define CMD_INTERP_REGS_SVH

`define OFS_REQ_ADDR 8'h00
`define OFS_CMD_WORD 8'h04
`define OFS_REQ_DATA 8'h08
`define OFS_IO_IN 8'h0c
`define OFS_RSP_ADDR 8'h10
`define OFS_RSP_CMD 8'h14
`define OFS_RSP_DATA 8'h18
`define OFS_STATUS 8'h1c
`define OFS_NV_CMD 8'h20
`define OFS_WORK_BASE 8'h40
`define OFS_NV_BASE 8'h60

`define RST_HALF 16'h0000
`define RST_WORD 32'h0000_0000

`define EXEC_BIT 14
`define CODE_MON_ALARM 14'h2040
`define CODE_WR_TRAVEL 14'h1200
`define CODE_WR_MASK 14'h3ff8

`define RSP_ACK_BIT 14
`define RSP_ERR_BIT 15
`define ST_ACK_BIT 0
`define ST_MON_BIT 1
`define ST_ERR_BIT 2

`define IO_SEL_LSB 0
`define IO_START 3
`define IO_HOME 4
`define IO_STOP 5
`define IO_FREE 6
`define IO_ALM_CLR 7
`define IO_DSEL_LSB 8
`define IO_SEQUENTIAL_START 11
`define IO_JOG_P 12
`define IO_JOG_M 13
`define IO_FWD 14
`define IO_RVS 15

`define HSIZE_WORD 3'b010

`endif

// ### hdl/cmd_interp_pkg.sv
/*
  Types shared by the command interpreter: its state encoding and the
  motion control bundle. Assumes the register header is included alongside.
*/
package cmd_interp_pkg;

  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_write = 4'b0010,
    st_mon = 4'b0100,
    st_hold = 4'b1000
  } state_t;

  typedef struct packed {
    logic start;
    logic [2:0] data_select;
    logic [31:0] travel;
    logic home;
    logic stop;
    logic free;
    logic alarm_clear;
    logic [2:0] direct_select;
    logic sequential_start;
    logic jog_plus;
    logic jog_minus;
    logic forward_run;
    logic reverse_run;
  } motion_t;

endpackage

// ### tb/host_model.sv
/*
  Bus master model standing for the network converter that relays the host.
  Assumes one AHB-Lite slave whose hreadyout is fed back as hready.
*/
module host_model (
  // Clock
  input wire logic mclk,
  // Request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // Answer
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
  end

  // The answer is taken at the very rising edge at which hready is high.
  // The request stays put until then, however many wait states come first.
  task automatic wait_rdy(output logic [31:0] d);
    logic r;
    r = 1'b0;
    while (r !== 1'b1) begin
      @(posedge mclk);
      r = hready;
    end
    d = hrdata;
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    logic [31:0] junk;
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy(junk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? wd : ~hwdata;
    wait_rdy(rd);
    // Released data must not keep showing the last value.
    hwdata <= ~wd;
  endtask
endmodule // host_model

// ### tb/tb_top.sv
/*
  Self-checking bench of the command interpreter.
  Assumes the register header and package of the design are compiled.
*/
`include "cmd_interp_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, srst, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, trav_seen;
  logic [1:0] htrans;
  logic [2:0] hsize, sel_seen;
  logic [15:0] node_addr, w;
  logic [7:0] alarm_code;
  cmd_interp_pkg::motion_t motion;
  int n_fail = 0;
  int n_checks = 0;
  int n_start = 0;

  cmd_interp u_cmd_interp (.mclk(mclk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .node_addr(node_addr),
    .alarm_code(alarm_code), .motion(motion));
  host_model u_host_model (.mclk(mclk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(negedge mclk) begin
    if (motion.start === 1'b1) begin
      n_start++;
      sel_seen = motion.data_select;
      trav_seen = motion.travel;
    end
  end

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    u_host_model.xfer(1'b1, a, d, x);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    logic [31:0] d;
    u_host_model.xfer(1'b0, a, 32'h0000_0000, d);
    chk(nm, d, e);
  endtask

  task automatic poll(input int b);
    logic [31:0] d;
    d = 32'h0000_0000;
    for (int i = 0; i < 10 && d[b] !== 1'b1; i++) begin
      u_host_model.xfer(1'b0, `OFS_STATUS, 32'h0000_0000, d);
    end
  endtask

  task automatic t_write;
    wr(`OFS_REQ_ADDR, {16'h0000, node_addr});
    wr(`OFS_REQ_DATA, 32'h0000_1388);
    wr(`OFS_CMD_WORD, 32'h0000_5201);
    poll(0);
    rchk("ack", `OFS_STATUS, 32'h0000_0001);
    rchk("rsp addr", `OFS_RSP_ADDR, {16'h0000, node_addr});
    rchk("rsp cmd", `OFS_RSP_CMD, 32'h0000_5201);
    rchk("entry1", `OFS_WORK_BASE + 8'h04, 32'h0000_1388);
    rchk("nv1 kept", `OFS_NV_BASE + 8'h04, 32'h0000_0000);
    wr(`OFS_REQ_DATA, 32'h0000_2222);
    rchk("no repeat", `OFS_WORK_BASE + 8'h04, 32'h0000_1388);
    wr(`OFS_CMD_WORD, 32'h0000_0000);
    rchk("ack clear", `OFS_STATUS, 32'h0000_0000);
    wr(`OFS_NV_CMD, 32'h0000_0001);
    repeat (3) @(posedge mclk);
    rchk("nv copy", `OFS_NV_BASE + 8'h04, 32'h0000_1388);
    wr(`OFS_CMD_WORD, 32'h0000_4123);
    poll(2);
    rchk("bad code", `OFS_RSP_CMD, 32'h0000_8123);
    wr(`OFS_CMD_WORD, 32'h0000_0000);
  endtask

  task automatic t_motion;
    wr(`OFS_IO_IN, 32'h0000_0009);
    repeat (2) @(posedge mclk);
    #1;
    chk("select", {29'h0, sel_seen}, 32'h0000_0001);
    chk("travel", trav_seen, 32'h0000_1388);
    for (int k = 4; k < 16; k++) begin
      w = 16'h0009 | (16'h0001 << k);
      wr(`OFS_IO_IN, {16'h0000, w});
      repeat (2) @(posedge mclk);
      #1;
      chk("levels", {motion.home, motion.stop, motion.free,
        motion.alarm_clear, motion.direct_select, motion.sequential_start,
        motion.jog_plus, motion.jog_minus, motion.forward_run,
        motion.reverse_run}, {w[4], w[5], w[6], w[7], w[10:8], w[11],
        w[12], w[13], w[14], w[15]});
    end
    chk("start once", n_start, 1);
    wr(`OFS_IO_IN, 32'h0000_0000);
  endtask

  task automatic t_monitor;
    alarm_code <= 8'h70;
    wr(`OFS_CMD_WORD, 32'h0000_6040);
    poll(1);
    rchk("mon data", `OFS_RSP_DATA, 32'h0000_0070);
    rchk("mon echo", `OFS_RSP_CMD, 32'h0000_6040);
    alarm_code <= 8'h33;
    repeat (3) @(posedge mclk);
    rchk("mon track", `OFS_RSP_DATA, 32'h0000_0033);
    wr(`OFS_CMD_WORD, 32'h0000_0000);
    alarm_code <= 8'h44;
    repeat (3) @(posedge mclk);
    rchk("mon frozen", `OFS_RSP_DATA, 32'h0000_0033);
    wr(`OFS_REQ_ADDR, {16'h0000, node_addr + 16'h0001});
    wr(`OFS_CMD_WORD, 32'h0000_6040);
    repeat (4) @(posedge mclk);
    rchk("other axis", `OFS_STATUS, 32'h0000_0000);
    wr(`OFS_CMD_WORD, 32'h0000_0000);
    wr(`OFS_RSP_DATA, 32'hffff_ffff);
    rchk("read only", `OFS_RSP_DATA, 32'h0000_0033);
    wr(8'h84, 32'hdead_beef);
    rchk("unmapped", 8'h84, 32'h0000_0000);
    chk("hresp", {31'h0, hresp}, 32'h0000_0000);
  endtask

  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #100us;
    n_fail++;
    final_report;
  end

  initial begin
    srst = 1'b1;
    node_addr = 16'h0003;
    alarm_code = 8'h00;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    rchk("status rst", `OFS_STATUS, 32'h0000_0000);
    rchk("entry rst", `OFS_WORK_BASE + 8'h04, 32'h0000_0000);
    t_write;
    t_motion;
    t_monitor;
    final_report;
  end
endmodule // tb_top
